/* design/gpb_pkg.sv */
`default_nettype none
package gpb_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int unsigned PINS       = 8;
    localparam int unsigned ADDR_W     = 10;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [9:0] OFS_DIR     = 10'h000;
    localparam logic [9:0] OFS_SENSE   = 10'h004;
    localparam logic [9:0] OFS_BOTH    = 10'h008;
    localparam logic [9:0] OFS_EVENT   = 10'h00c;
    localparam logic [9:0] OFS_MASK    = 10'h010;
    localparam logic [9:0] OFS_RAW     = 10'h014;
    localparam logic [9:0] OFS_MIS     = 10'h018;
    localparam logic [9:0] OFS_CLEAR   = 10'h01c;
    localparam logic [9:0] OFS_AFSEL   = 10'h020;
    localparam logic [9:0] OFS_DR2     = 10'h100;
    localparam logic [9:0] OFS_DR4     = 10'h104;
    localparam logic [9:0] OFS_DR8     = 10'h108;
    localparam logic [9:0] OFS_ODR     = 10'h10c;
    localparam logic [9:0] OFS_PUR     = 10'h110;
    localparam logic [9:0] OFS_PDR     = 10'h114;
    localparam logic [9:0] OFS_SLR     = 10'h118;
    localparam logic [9:0] OFS_DEN     = 10'h11c;
    localparam logic [9:0] OFS_LOCK    = 10'h120;
    localparam logic [9:0] OFS_COMMIT  = 10'h124;

    // ------------------------------------------------------------
    // lock key and reset values
    // ------------------------------------------------------------
    // unlock key value is arbitrary
    localparam logic [31:0] LOCK_KEY     = 32'h5a5a0c3e;
    localparam logic [7:0]  RST_DR2      = 8'hff;
    localparam logic [7:0]  RST_ZERO     = 8'h00;
    localparam logic [31:0] UNMAPPED_VAL = 32'h00000000;

    typedef struct packed {
        logic [7:0] drive_low_select;
        logic [7:0] drive_mid_select;
        logic [7:0] drive_high_select;
        logic [7:0] open_drain_select;
        logic [7:0] pull_up_select;
        logic [7:0] pull_down_select;
        logic [7:0] slew_rate_select;
        logic [7:0] pin_digital_enable;
    } gpb_pad_t;

endpackage : gpb_pkg
`default_nettype wire

/* design/gpb_port.sv */
`default_nettype none
module gpb_port #(
    parameter logic [7:0] PROTECT_MASK = 8'h00,
    parameter int         TRIG_PIN     = 4,
    parameter bit         HAS_TRIG     = 1'b0
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    input  wire logic [11:0]          avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [31:0]          avs_writedata,
    input  wire logic [3:0]           avs_byteenable,
    output var  logic [31:0]          avs_readdata,
    output var  logic                 avs_waitrequest,
    input  wire logic [7:0]           pin_in,
    output var  logic [7:0]           pin_out,
    output var  logic [7:0]           pin_oe,
    input  wire logic [7:0]           alt_out,
    input  wire logic [7:0]           alt_oe,
    output var  logic [7:0]           alt_in,
    output var  gpb_pkg::gpb_pad_t    pad_cfg,
    output var  logic                 port_irq,
    output var  logic                 adc_trigger
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (TRIG_PIN < 0 || TRIG_PIN > 7) begin : g_bad_trig
        $error("trigger pin index out of range");
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]        data_q;
    logic [7:0]        data_d;
    logic [7:0]        dir_q;
    logic [7:0]        sense_q;
    logic [7:0]        both_q;
    logic [7:0]        event_q;
    logic [7:0]        mask_q;
    logic [7:0]        latch_q;
    logic [7:0]        latch_d;
    logic [7:0]        clr_bits;
    logic [7:0]        afsel_q;
    logic [7:0]        commit_q;
    logic [7:0]        pin_prev_q;
    logic              unlocked_q;
    gpb_pkg::gpb_pad_t pad_q;
    logic              ack_q;
    logic              pend_q;
    logic [7:0]        raw;
    logic [7:0]        mis;
    logic [7:0]        edge_hit;
    logic [7:0]        wmask;
    logic              data_sel;
    logic              wr;
    logic              rd;
    logic              cfg_sel;
    logic [9:0]        ofs;
    logic [31:0]       rdata_d;

    function automatic logic [7:0] apply_mask(input logic [7:0] oldv, input logic [7:0] newv,
                                              input logic [7:0] m);
        apply_mask = (oldv & ~m) | (newv & m);
    endfunction : apply_mask

    // ------------------------------------------------------------
    // bus decode: word 0x000..0x3fc is data, 0x400..0x7fc config
    // ------------------------------------------------------------
    assign data_sel = ~avs_address[10] & ~avs_address[11];
    assign cfg_sel  = avs_address[10] & ~avs_address[11];
    assign ofs      = {avs_address[9:2], 2'b00};
    assign wmask    = avs_address[9:2];
    assign wr       = avs_write & ~ack_q & avs_byteenable[0];
    assign rd       = avs_read & ~ack_q;

    // one wait cycle, then ack
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= (avs_read | avs_write) & ~ack_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
        end
    end

    // ------------------------------------------------------------
    // data register
    // ------------------------------------------------------------
    logic [7:0] pin_val;
    assign pin_val = pin_in;

    // inputs follow the pin, outputs keep the stored bit
    always_comb begin
        data_d = (data_q & dir_q) | (pin_val & ~dir_q);
        if (wr && data_sel) begin
            data_d = apply_mask(data_d, avs_writedata[7:0], wmask & dir_q);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            data_q <= gpb_pkg::RST_ZERO;
        end else begin
            data_q <= data_d;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            dir_q   <= gpb_pkg::RST_ZERO;
            sense_q <= gpb_pkg::RST_ZERO;
            both_q  <= gpb_pkg::RST_ZERO;
            event_q <= gpb_pkg::RST_ZERO;
            mask_q  <= gpb_pkg::RST_ZERO;
        end else if (wr && cfg_sel) begin
            unique case (ofs)
                gpb_pkg::OFS_DIR:   dir_q   <= avs_writedata[7:0];
                gpb_pkg::OFS_SENSE: sense_q <= avs_writedata[7:0];
                gpb_pkg::OFS_BOTH:  both_q  <= avs_writedata[7:0];
                gpb_pkg::OFS_EVENT: event_q <= avs_writedata[7:0];
                gpb_pkg::OFS_MASK:  mask_q  <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            afsel_q <= PROTECT_MASK;
        end else if (wr && cfg_sel && ofs == gpb_pkg::OFS_AFSEL) begin
            // protected bits only with unlock and commit
            afsel_q <= apply_mask(afsel_q, avs_writedata[7:0],
                                  ~PROTECT_MASK | (commit_q & {8{unlocked_q}}));
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            unlocked_q <= 1'b0;
        end else if (wr && cfg_sel && ofs == gpb_pkg::OFS_LOCK) begin
            unlocked_q <= (avs_writedata == gpb_pkg::LOCK_KEY);
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            commit_q <= gpb_pkg::RST_ZERO;
        end else if (wr && cfg_sel && ofs == gpb_pkg::OFS_COMMIT && unlocked_q) begin
            commit_q <= avs_writedata[7:0] & PROTECT_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pad_q.drive_low_select   <= gpb_pkg::RST_DR2;
            pad_q.drive_mid_select   <= gpb_pkg::RST_ZERO;
            pad_q.drive_high_select  <= gpb_pkg::RST_ZERO;
            pad_q.open_drain_select  <= gpb_pkg::RST_ZERO;
            pad_q.pull_up_select     <= PROTECT_MASK;
            pad_q.pull_down_select   <= gpb_pkg::RST_ZERO;
            pad_q.slew_rate_select   <= gpb_pkg::RST_ZERO;
            pad_q.pin_digital_enable <= PROTECT_MASK;
        end else if (wr && cfg_sel) begin
            unique case (ofs)
                gpb_pkg::OFS_DR2: pad_q.drive_low_select   <= avs_writedata[7:0];
                gpb_pkg::OFS_DR4: pad_q.drive_mid_select   <= avs_writedata[7:0];
                gpb_pkg::OFS_DR8: pad_q.drive_high_select  <= avs_writedata[7:0];
                gpb_pkg::OFS_ODR: pad_q.open_drain_select  <= avs_writedata[7:0];
                gpb_pkg::OFS_PUR: pad_q.pull_up_select     <= avs_writedata[7:0];
                gpb_pkg::OFS_PDR: pad_q.pull_down_select   <= avs_writedata[7:0];
                gpb_pkg::OFS_SLR: pad_q.slew_rate_select   <= avs_writedata[7:0];
                gpb_pkg::OFS_DEN: pad_q.pin_digital_enable <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // interrupt detection
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_prev_q <= gpb_pkg::RST_ZERO;
        end else begin
            pin_prev_q <= pin_in;
        end
    end

    assign edge_hit = (both_q & (pin_in ^ pin_prev_q)) |
                      (~both_q & event_q & pin_in & ~pin_prev_q) |
                      (~both_q & ~event_q & ~pin_in & pin_prev_q);

    assign clr_bits = (wr && cfg_sel && ofs == gpb_pkg::OFS_CLEAR) ?
                      avs_writedata[7:0] : 8'h00;
    // new edge wins over clear
    assign latch_d  = ((latch_q & ~clr_bits) | edge_hit) & ~sense_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            latch_q <= gpb_pkg::RST_ZERO;
        end else begin
            latch_q <= latch_d;
        end
    end

    // level condition follows the pin directly
    assign raw = latch_q | (sense_q & ~(pin_in ^ event_q));
    assign mis = raw & mask_q;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            port_irq <= 1'b0;
        end else begin
            port_irq <= |mis;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pend_q      <= 1'b0;
            adc_trigger <= 1'b0;
        end else begin
            pend_q      <= HAS_TRIG & mis[TRIG_PIN];
            adc_trigger <= HAS_TRIG & mis[TRIG_PIN] & ~pend_q;
        end
    end

    // ------------------------------------------------------------
    // pin muxing
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pin_out <= gpb_pkg::RST_ZERO;
            pin_oe  <= gpb_pkg::RST_ZERO;
            alt_in  <= gpb_pkg::RST_ZERO;
            // pads show their defaults already while reset is held
            pad_cfg.drive_low_select   <= gpb_pkg::RST_DR2;
            pad_cfg.drive_mid_select   <= gpb_pkg::RST_ZERO;
            pad_cfg.drive_high_select  <= gpb_pkg::RST_ZERO;
            pad_cfg.open_drain_select  <= gpb_pkg::RST_ZERO;
            pad_cfg.pull_up_select     <= PROTECT_MASK;
            pad_cfg.pull_down_select   <= gpb_pkg::RST_ZERO;
            pad_cfg.slew_rate_select   <= gpb_pkg::RST_ZERO;
            pad_cfg.pin_digital_enable <= PROTECT_MASK;
        end else begin
            pin_out <= (afsel_q & alt_out) | (~afsel_q & data_q & dir_q);
            pin_oe  <= ((afsel_q & alt_oe) | (~afsel_q & dir_q)) & pad_q.pin_digital_enable;
            alt_in  <= pin_in & afsel_q & pad_q.pin_digital_enable;
            pad_cfg <= pad_q;
        end
    end

    // ------------------------------------------------------------
    // read data
    // ------------------------------------------------------------
    always_comb begin
        rdata_d = gpb_pkg::UNMAPPED_VAL;
        if (data_sel) begin
            rdata_d = {24'h000000, data_q & wmask};
        end else if (cfg_sel) begin
            unique case (ofs)
                gpb_pkg::OFS_DIR:    rdata_d = {24'h000000, dir_q};
                gpb_pkg::OFS_SENSE:  rdata_d = {24'h000000, sense_q};
                gpb_pkg::OFS_BOTH:   rdata_d = {24'h000000, both_q};
                gpb_pkg::OFS_EVENT:  rdata_d = {24'h000000, event_q};
                gpb_pkg::OFS_MASK:   rdata_d = {24'h000000, mask_q};
                gpb_pkg::OFS_RAW:    rdata_d = {24'h000000, raw};
                gpb_pkg::OFS_MIS:    rdata_d = {24'h000000, mis};
                gpb_pkg::OFS_AFSEL:  rdata_d = {24'h000000, afsel_q};
                gpb_pkg::OFS_DR2:    rdata_d = {24'h000000, pad_q.drive_low_select};
                gpb_pkg::OFS_DR4:    rdata_d = {24'h000000, pad_q.drive_mid_select};
                gpb_pkg::OFS_DR8:    rdata_d = {24'h000000, pad_q.drive_high_select};
                gpb_pkg::OFS_ODR:    rdata_d = {24'h000000, pad_q.open_drain_select};
                gpb_pkg::OFS_PUR:    rdata_d = {24'h000000, pad_q.pull_up_select};
                gpb_pkg::OFS_PDR:    rdata_d = {24'h000000, pad_q.pull_down_select};
                gpb_pkg::OFS_SLR:    rdata_d = {24'h000000, pad_q.slew_rate_select};
                gpb_pkg::OFS_DEN:    rdata_d = {24'h000000, pad_q.pin_digital_enable};
                gpb_pkg::OFS_LOCK:   rdata_d = {31'h00000000, ~unlocked_q};
                gpb_pkg::OFS_COMMIT: rdata_d = {24'h000000, commit_q | ~PROTECT_MASK};
                default:             rdata_d = gpb_pkg::UNMAPPED_VAL;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            avs_readdata <= gpb_pkg::UNMAPPED_VAL;
        end else if (rd) begin
            avs_readdata <= rdata_d;
        end
    end

endmodule : gpb_port
`default_nettype wire

/* sim/gpb_pin_model.sv */
`default_nettype none
module gpb_pin_model (
    input  wire logic              clk,
    input  wire logic [7:0]        pin_out,
    input  wire logic [7:0]        pin_oe,
    input  wire gpb_pkg::gpb_pad_t pad_cfg,
    input  wire logic [7:0]        ext_val,
    input  wire logic [7:0]        ext_en,
    output var  logic [7:0]        pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // open-drain high releases the wire; undriven pins follow pull-up, else settle low
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (pin_oe[i] && !(pad_cfg.open_drain_select[i] && pin_out[i])) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pad_cfg.pull_up_select[i]) pin_in[i] = 1'b1;
            else if (pad_cfg.pull_down_select[i]) pin_in[i] = 1'b0;
            else pin_in[i] = 1'b0;
        end
    end
endmodule : gpb_pin_model
`default_nettype wire

/* sim/gpb_port_sva.sv */
`default_nettype none
module gpb_port_sva #(
    parameter logic [7:0] PROTECT_MASK = 8'h00
) (
    input wire logic              clk,
    input wire logic              reset_n,
    input wire logic              avs_read,
    input wire logic              avs_write,
    input wire logic              avs_waitrequest,
    input wire logic [7:0]        pin_oe,
    input wire logic [7:0]        alt_in,
    input wire gpb_pkg::gpb_pad_t pad_cfg,
    input wire logic              port_irq,
    input wire logic              adc_trigger
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_wait_answer: assert property (s_req |=> s_ack)
        else $error("access not answered one cycle later");
    a_no_spurious: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
        else $error("answer without request");
    a_reset_quiet: assert property (reset_n && !$past(reset_n) |->
        avs_waitrequest && pin_oe == 8'h00 && !port_irq && !adc_trigger)
        else $error("outputs active right after reset");
    a_reset_pads: assert property (reset_n && !$past(reset_n) && !$past(reset_n, 2) |->
        pad_cfg.pull_up_select == PROTECT_MASK && pad_cfg.pin_digital_enable == PROTECT_MASK
        && pad_cfg.pull_down_select == 8'h00 && pad_cfg.drive_low_select == 8'hff)
        else $error("pad defaults wrong after reset");
    a_oe_digital: assert property ((pin_oe & ~pad_cfg.pin_digital_enable) == 8'h00)
        else $error("pin driven without digital enable");
    a_alt_digital: assert property ((alt_in & ~pad_cfg.pin_digital_enable) == 8'h00)
        else $error("alt input passed without digital enable");
    a_trig_pulse: assert property (adc_trigger |=> !adc_trigger)
        else $error("trigger longer than one cycle");
    a_trig_irq: assert property (adc_trigger |-> port_irq)
        else $error("trigger without port interrupt");
endmodule : gpb_port_sva
bind gpb_port gpb_port_sva #(.PROTECT_MASK(PROTECT_MASK)) gpb_port_sva_i (
    .clk(clk), .reset_n(reset_n), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .pin_oe(pin_oe), .alt_in(alt_in),
    .pad_cfg(pad_cfg), .port_irq(port_irq), .adc_trigger(adc_trigger));
`default_nettype wire

/* sim/test_gpb_port_block.sv */
`default_nettype none
module test_gpb_port_block;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] DIR = {2'b01, gpb_pkg::OFS_DIR}, SEN = {2'b01, gpb_pkg::OFS_SENSE},
        BTH = {2'b01, gpb_pkg::OFS_BOTH}, EVT = {2'b01, gpb_pkg::OFS_EVENT},
        MSK = {2'b01, gpb_pkg::OFS_MASK}, RAW = {2'b01, gpb_pkg::OFS_RAW},
        MIS = {2'b01, gpb_pkg::OFS_MIS}, CLR = {2'b01, gpb_pkg::OFS_CLEAR},
        AFS = {2'b01, gpb_pkg::OFS_AFSEL}, DR2 = {2'b01, gpb_pkg::OFS_DR2},
        DR8 = {2'b01, gpb_pkg::OFS_DR8}, PUR = {2'b01, gpb_pkg::OFS_PUR},
        PDR = {2'b01, gpb_pkg::OFS_PDR}, DEN = {2'b01, gpb_pkg::OFS_DEN},
        LCK = {2'b01, gpb_pkg::OFS_LOCK}, CMT = {2'b01, gpb_pkg::OFS_COMMIT};
    logic              clk = 1'b0;
    logic              reset_n = 1'b0;
    logic [11:0]       avs_address = 12'h000;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [31:0]       avs_writedata = 32'h00000000;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic [7:0]        pin_in, pin_out, pin_oe, alt_in;
    logic [7:0]        alt_out = 8'h00;
    logic [7:0]        alt_oe = 8'h00;
    logic [7:0]        ext_val = 8'h00;
    logic [7:0]        ext_en = 8'hf0;
    gpb_pkg::gpb_pad_t pad_cfg;
    logic              port_irq, adc_trigger;
    logic [31:0]       rv;
    int                error_cnt = 0;
    int                num_checks = 0;
    int                trig_cnt = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk) if (adc_trigger === 1'b1) trig_cnt++;
    gpb_port #(.PROTECT_MASK(8'h80), .TRIG_PIN(4), .HAS_TRIG(1'b1)) gpb_port_i (
        .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe),
        .alt_in(alt_in), .pad_cfg(pad_cfg), .port_irq(port_irq), .adc_trigger(adc_trigger));
    gpb_pin_model gpb_pin_model_i (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
        .pad_cfg(pad_cfg), .ext_val(ext_val), .ext_en(ext_en), .pin_in(pin_in));
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rv = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (avs_waitrequest !== 1'b0) begin
            error_cnt++;
            close_out();
        end
    endtask : acc
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        acc(1'b1, a, d);
    endtask : wr
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
        acc(1'b0, a, 32'h00000000);
        chk(nm, rv, e);
    endtask : rdc
    task automatic pins(input logic [7:0] v);
        @(posedge clk);
        ext_val <= v;
        acc(1'b0, RAW, 32'h00000000);
    endtask : pins
    initial begin
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rdc("dir", DIR, 32'h00);
        rdc("afsel", AFS, 32'h80);
        rdc("pur", PUR, 32'h80);
        rdc("den", DEN, 32'h80);
        rdc("pdr", PDR, 32'h00);
        rdc("dr2", DR2, 32'hff);
        rdc("lock", LCK, 32'h01);
        rdc("commit", CMT, 32'h7f);
        wr(12'h5fc, 32'hff);
        rdc("unmapped", 12'h5fc, 32'h00);
        wr(DEN, 32'hff);
        wr(DIR, 32'h0f);
        wr(DR8, 32'h01);
        pins(8'ha0);
        chk("dr8 pad", {24'h0, pad_cfg.drive_high_select}, 32'h01);
        wr(12'h098, 32'heb);
        rdc("data full", 12'h3fc, 32'ha2);
        chk("drive", {16'h0, pin_oe, pin_out & 8'h0f}, 32'h0f02);
        rdc("data masked", 12'h0c4, 32'h20);
        wr(12'h3fc, 32'hff);
        rdc("data outs", 12'h3fc, 32'haf);
        wr(12'h004, 32'h00);
        rdc("data alias", 12'h3fc, 32'hae);
        wr(EVT, 32'h20);
        wr(CLR, 32'hff);
        wr(MSK, 32'h20);
        pins(8'h80);
        pins(8'ha0);
        rdc("raw rise", RAW, 32'h20);
        rdc("mis rise", MIS, 32'h20);
        chk("irq", {31'h0, port_irq}, 32'h1);
        pins(8'h80);
        pins(8'ha0);
        wr(CLR, 32'h00);
        rdc("raw zero clr", RAW, 32'h20);
        wr(CLR, 32'h20);
        rdc("raw cleared", RAW, 32'h00);
        chk("irq clr", {31'h0, port_irq}, 32'h0);
        wr(MSK, 32'h00);
        pins(8'h80);
        pins(8'ha0);
        rdc("raw masked", RAW, 32'h20);
        rdc("mis masked", MIS, 32'h00);
        chk("irq masked", {31'h0, port_irq}, 32'h0);
        wr(SEN, 32'h40);
        wr(CLR, 32'hff);
        wr(MSK, 32'h40);
        rdc("raw level", RAW, 32'h40);
        chk("irq level", {31'h0, port_irq}, 32'h1);
        pins(8'he0);
        rdc("raw lvl gone", RAW, 32'h00);
        wr(MSK, 32'h00);
        wr(SEN, 32'h00);
        wr(EVT, 32'h00);
        wr(BTH, 32'h10);
        wr(CLR, 32'hff);
        wr(MSK, 32'h10);
        pins(8'hf0);
        rdc("raw both r", RAW, 32'h10);
        wr(CLR, 32'h10);
        pins(8'he0);
        rdc("raw both f", RAW, 32'h10);
        chk("trig count", trig_cnt, 32'h2);
        chk("irq trig", {31'h0, port_irq}, 32'h1);
        wr(AFS, 32'h01);
        rdc("afsel open", AFS, 32'h81);
        @(posedge clk);
        alt_oe <= 8'h01;
        alt_out <= 8'h01;
        rdc("afsel again", AFS, 32'h81);
        chk("alt path", {29'h0, pin_oe[0], pin_out[0], alt_in[0]}, 32'h7);
        wr(AFS, 32'h00);
        rdc("afsel locked", AFS, 32'h80);
        wr(CMT, 32'hff);
        rdc("commit locked", CMT, 32'h7f);
        wr(LCK, gpb_pkg::LOCK_KEY);
        rdc("unlocked", LCK, 32'h00);
        wr(CMT, 32'hff);
        rdc("commit open", CMT, 32'hff);
        wr(AFS, 32'h00);
        rdc("afsel commit", AFS, 32'h00);
        wr({2'b01, gpb_pkg::OFS_SLR}, 32'h3c);
        rdc("slr", {2'b01, gpb_pkg::OFS_SLR}, 32'h3c);
        chk("slr pad", {24'h0, pad_cfg.slew_rate_select}, 32'h3c);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rdc("afsel rst", AFS, 32'h80);
        rdc("dir rst", DIR, 32'h00);
        rdc("commit rst", CMT, 32'h7f);
        rdc("slr rst", {2'b01, gpb_pkg::OFS_SLR}, 32'h00);
        chk("pur pad rst", {24'h0, pad_cfg.pull_up_select}, 32'h80);
        close_out();
    end
endmodule : test_gpb_port_block
`default_nettype wire
